// *** design/dmaen_ctrl.sv ***
// Purpose: Channel enable and interrupt enable control of a DMA controller
// Assumes: Activation requests and controller strobe come from ref_clk_i logic
// Notes: nmi_i is asynchronous and passes a two-stage synchroniser
`include "dmaen_cfg.svh"

module dmaen_ctrl
   import dmaen_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter logic [15:0] INT_SRC_MASK = `DMAEN_INT_SRC_MASK
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   // Avalon-MM slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Access made by the data transfer controller
   input wire logic dtc_access_i,
   // Activation sources and NMI
   input wire logic [15:0] act_req_i,
   input wire logic nmi_i,
   // Transfer strobes and bus ownership
   output logic ch0_xfer_o,
   output logic ch1_xfer_o,
   output logic bus_master_o,
   // Interrupt requests
   output logic [1:0] fwd_irq_o,
   output logic ch0_end_irq_o,
   output logic ch1_break_irq_o,
   output logic irq_o
);

   typedef struct packed {
      logic nmi1;
      logic nmi2;
      logic nmi3;
      logic waitreq;
      logic [31:0] rdata;
      logic [3:0] en;
      logic [3:0] arm;
      logic c0_end_en;
      logic c1_brk_en;
      logic [3:0] src0;
      logic [3:0] src1;
      logic burst0;
      logic [CNT_W-1:0] cnt0;
      logic [CNT_W-1:0] cnt1;
      dmaen_st_e st;
      logic x0;
      logic x1;
      logic busm;
      logic [1:0] fwd;
      logic end0;
      logic brk1;
      logic [3:0] stat;
      logic [3:0] mask;
      logic irq;
   } dmaen_state_s;

   // Enable vector: 0 ch0 transfer, 1 ch0 master, 2 ch1 transfer, 3 ch1 master
   localparam int EN_POS [4] = '{`DMAEN_B_C0_TE, `DMAEN_B_C0_ME,
                                 `DMAEN_B_C1_TE, `DMAEN_B_C1_ME};

   dmaen_state_s q;
   dmaen_state_s d;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] ctrl_word(input dmaen_state_s s);
      logic [31:0] w;
      w = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         w[EN_POS[i]] = s.en[i];
      end
      w[`DMAEN_B_C0_END] = s.c0_end_en;
      w[`DMAEN_B_C1_BRK] = s.c1_brk_en;
      return w;
   endfunction

   logic acc;
   logic wr;
   logic wr_ctrl;
   logic rd_ctrl;
   logic nmi_edge;
   logic sel0;
   logic sel1;
   logic run0;
   logic run1;
   logic [31:0] rmux;
   logic [31:0] cfgw;
   logic [3:0] set_ev;

   always_comb begin
      d = q;
      d.nmi1 = nmi_i;
      d.nmi2 = q.nmi1;
      d.nmi3 = q.nmi2;
      nmi_edge = q.nmi2 & ~q.nmi3;
      acc = (avs_read_i | avs_write_i) & q.waitreq;
      wr = acc & avs_write_i;
      wr_ctrl = wr & hit(avs_address_i, `DMAEN_OFF_CTRL) & avs_byteenable_i[0];
      rd_ctrl = acc & avs_read_i & ~dtc_access_i & hit(avs_address_i, `DMAEN_OFF_CTRL);
      d.waitreq = ~acc;
      set_ev = 4'h0;

      // Read answer, unmapped reads as zero
      cfgw = 32'h0000_0000;
      cfgw[`DMAEN_F_SRC0 +: 4] = q.src0;
      cfgw[`DMAEN_B_BURST0] = q.burst0;
      cfgw[`DMAEN_F_SRC1 +: 4] = q.src1;
      rmux = 32'h0000_0000;
      if (hit(avs_address_i, `DMAEN_OFF_CTRL)) begin
         rmux = ctrl_word(q);
      end else if (hit(avs_address_i, `DMAEN_OFF_CFG)) begin
         rmux = cfgw;
      end else if (hit(avs_address_i, `DMAEN_OFF_CNT0)) begin
         rmux[CNT_W-1:0] = q.cnt0;
      end else if (hit(avs_address_i, `DMAEN_OFF_CNT1)) begin
         rmux[CNT_W-1:0] = q.cnt1;
      end else if (hit(avs_address_i, `DMAEN_OFF_STAT)) begin
         rmux[3:0] = q.stat;
      end else if (hit(avs_address_i, `DMAEN_OFF_MASK)) begin
         rmux[3:0] = q.mask;
      end else if (hit(avs_address_i, `DMAEN_OFF_STATE)) begin
         rmux[3:0] = {q.busm, q.st == S_BURST, q.en[3] & q.en[2], q.en[1] & q.en[0]};
      end
      if (acc & avs_read_i) begin
         d.rdata = rmux;
      end

      // Enable bits: clear on zero, set on one when armed, transfer enables also on a controller access
      for (int i = 0; i < 4; i++) begin
         if (wr_ctrl) begin
            if (!avs_writedata_i[EN_POS[i]]) begin
               d.en[i] = 1'b0;
            end else if (q.arm[i] | (dtc_access_i & (i % 2 == 0))) begin
               d.en[i] = 1'b1;
            end
            if (!dtc_access_i) begin
               d.arm[i] = 1'b0;
            end
         end else if (rd_ctrl) begin
            d.arm[i] = ~q.en[i];
         end
      end
      if (wr_ctrl) begin
         d.c0_end_en = avs_writedata_i[`DMAEN_B_C0_END];
         d.c1_brk_en = avs_writedata_i[`DMAEN_B_C1_BRK];
      end
      if (wr & hit(avs_address_i, `DMAEN_OFF_CFG)) begin
         cfgw = merge(cfgw, avs_writedata_i, avs_byteenable_i);
         d.src0 = cfgw[`DMAEN_F_SRC0 +: 4];
         d.burst0 = cfgw[`DMAEN_B_BURST0];
         d.src1 = cfgw[`DMAEN_F_SRC1 +: 4];
      end
      if (wr & hit(avs_address_i, `DMAEN_OFF_CNT0)) begin
         d.cnt0 = CNT_W'(merge(32'(q.cnt0), avs_writedata_i, avs_byteenable_i));
      end
      if (wr & hit(avs_address_i, `DMAEN_OFF_CNT1)) begin
         d.cnt1 = CNT_W'(merge(32'(q.cnt1), avs_writedata_i, avs_byteenable_i));
      end
      if (wr & hit(avs_address_i, `DMAEN_OFF_MASK)) begin
         d.mask = 4'(merge(32'(q.mask), avs_writedata_i, avs_byteenable_i));
      end

      // Channel 0 sequencing
      sel0 = act_req_i[q.src0];
      run0 = q.en[0] & q.en[1];
      d.x0 = 1'b0;
      if (!q.en[0]) begin
         d.st = S_IDLE;
      end else if (nmi_edge & q.burst0 & run0 & (q.st == S_BURST)) begin
         d.en[1] = 1'b0;
         set_ev[`DMAEN_ST_NMI] = 1'b1;
      end else if (run0 & (q.cnt0 != '0) & (sel0 | (q.st == S_BURST))) begin
         d.x0 = 1'b1;
         d.cnt0 = q.cnt0 - CNT_W'(1);
         if (q.cnt0 == CNT_W'(1)) begin
            d.en[0] = 1'b0;
            d.st = S_IDLE;
         end else if (q.burst0) begin
            d.st = S_BURST;
         end
      end

      // Channel 1 sequencing
      sel1 = act_req_i[q.src1];
      run1 = q.en[2] & q.en[3];
      d.x1 = 1'b0;
      if (run1 & sel1 & (q.cnt1 != '0)) begin
         d.x1 = 1'b1;
         d.cnt1 = q.cnt1 - CNT_W'(1);
         if (q.cnt1 == CNT_W'(1)) begin
            d.en[2] = 1'b0;
         end
      end
      d.busm = (d.st == S_BURST) & d.en[0] & d.en[1];

      // Disabled internal sources go back to the interrupt controller
      d.fwd[0] = ~q.en[0] & sel0 & INT_SRC_MASK[q.src0];
      d.fwd[1] = ~q.en[2] & sel1 & INT_SRC_MASK[q.src1];
      set_ev[`DMAEN_ST_FWD] = |d.fwd & ~|q.fwd;

      // End and break requests
      d.end0 = d.c0_end_en & ~d.en[0] & (q.end0 | q.en[0]);
      d.brk1 = d.c1_brk_en & ~d.en[3] & (q.brk1 | q.en[3]);
      set_ev[`DMAEN_ST_END0] = d.end0 & ~q.end0;
      set_ev[`DMAEN_ST_BRK1] = d.brk1 & ~q.brk1;

      // Sticky status, set wins over write-one clear
      if (wr & hit(avs_address_i, `DMAEN_OFF_STAT) & avs_byteenable_i[0]) begin
         d.stat = q.stat & ~avs_writedata_i[3:0];
      end
      d.stat = d.stat | set_ev;
      d.irq = |(d.stat & d.mask);
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.waitreq <= `DMAEN_RST_WAIT;
      end else begin
         q <= d;
      end
   end

   assign avs_readdata_o = q.rdata;
   assign avs_waitrequest_o = q.waitreq;
   assign ch0_xfer_o = q.x0;
   assign ch1_xfer_o = q.x1;
   assign bus_master_o = q.busm;
   assign fwd_irq_o = q.fwd;
   assign ch0_end_irq_o = q.end0;
   assign ch1_break_irq_o = q.brk1;
   assign irq_o = q.irq;

   AST_CH0_RUN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      q.x0 |-> $past(q.en[0] && q.en[1]))
      else $error("ch0 transfer without both enables");

   AST_NMI_BURST: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (nmi_edge && q.burst0 && run0 && q.st == S_BURST) |=> (!q.en[1] && !q.x0 && !q.busm))
      else $error("burst NMI did not suspend ch0");

   AST_NMI_BLOCK: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (nmi_edge && !q.burst0 && q.en[1] && !wr_ctrl) |=> q.en[1])
      else $error("block mode NMI cleared master enable");

   AST_ME_ARMED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(q.en[1]) |-> $past(q.arm[1] && wr_ctrl))
      else $error("master enable set without zero read");

   AST_TE_ARMED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(q.en[0]) |-> $past(wr_ctrl && (q.arm[0] || dtc_access_i)))
      else $error("transfer enable set without zero read");

   AST_TE_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !q.en[0] |=> !q.x0)
      else $error("ch0 transferred while disabled");

   AST_FWD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (!q.en[0] && sel0 && INT_SRC_MASK[q.src0]) |=> fwd_irq_o[0])
      else $error("internal request not forwarded");

   AST_END_IRQ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      ($fell(q.en[0]) && q.c0_end_en) |-> q.end0 ##1 (q.end0 || !q.c0_end_en || q.en[0]))
      else $error("end request missing");

   AST_COUNT_END: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (q.x0 && q.cnt0 == '0) |-> !q.en[0])
      else $error("transfer enable kept after last transfer");

   AST_BRK: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      ($fell(q.en[3]) && q.c1_brk_en) |-> q.brk1)
      else $error("break request missing");

   AST_BRK_DROP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      q.brk1 |-> (q.c1_brk_en && !q.en[3]))
      else $error("break request not withdrawn");

   AST_IRQ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      irq_o == |(q.stat & q.mask))
      else $error("interrupt output mismatch");

   AST_WAIT_ONE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");

   AST_WAIT_ANSWER: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
      else $error("bus access not answered after one wait cycle");

   AST_RDATA_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
      else $error("read data changed without a read");

   AST_TE_CLR_WR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_ctrl && !avs_writedata_i[`DMAEN_B_C0_TE]) |=> !q.en[0])
      else $error("zero write did not clear transfer enable");

   AST_ME_CLR_WR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_ctrl && !avs_writedata_i[`DMAEN_B_C0_ME]) |=> !q.en[1])
      else $error("zero write did not clear master enable");

   AST_CH1_RUN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      q.x1 |-> $past(q.en[2] && q.en[3]))
      else $error("ch1 transfer without both enables");

   AST_C1_ARMED: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      $rose(q.en[3]) |-> $past(q.arm[3] && wr_ctrl))
      else $error("ch1 master enable set without zero read");

   AST_ARM_CLR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_ctrl && !dtc_access_i) |=> (q.arm == 4'h0))
      else $error("arm flags kept after control write");

   AST_ARM_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      rd_ctrl |=> (q.arm == ~$past(q.en)))
      else $error("arm flags do not follow the read value");

   AST_XFER_CNT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      q.x0 |-> (q.cnt0 == $past(q.cnt0) - CNT_W'(1)))
      else $error("ch0 count not decremented per transfer");

   AST_CH1_CNT0: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (q.cnt1 == '0) |=> !q.x1)
      else $error("ch1 transferred with zero count");

   AST_END_DROP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      q.end0 |-> (q.c0_end_en && !q.en[0]))
      else $error("end request not withdrawn");

   AST_FWD_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      q.en[0] |=> !fwd_irq_o[0])
      else $error("request forwarded while transfer enabled");

   AST_STAT_W1C: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      $fell(q.stat[0]) |->
         $past(avs_write_i && avs_writedata_i[0] && (avs_address_i == `DMAEN_OFF_STAT)))
      else $error("status bit cleared without write of one");

   AST_NMI_STAT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (nmi_edge && q.burst0 && run0 && q.st == S_BURST) |=> q.stat[`DMAEN_ST_NMI])
      else $error("NMI suspend not flagged");

   AST_RESUME: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (q.st == S_BURST && q.en[0] && q.en[1] && q.cnt0 != '0 && !nmi_edge) |=> q.x0)
      else $error("burst transfer did not continue");

   AST_BRK_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_ctrl && !avs_writedata_i[`DMAEN_B_C1_BRK]) |=> !ch1_break_irq_o)
      else $error("break request kept after disable");

   AST_END_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
      (wr_ctrl && !avs_writedata_i[`DMAEN_B_C0_END]) |=> !ch0_end_irq_o)
      else $error("end request kept after disable");

endmodule

// *** design/dmaen_cfg.svh ***
// Purpose: Offsets, field positions and reset values of the enable control
// Assumes: 32-bit Avalon-MM slave, byte addresses, one aligned word per register
// Notes: Included by the control block only
//
// What this block does
// - Channel 0 runs only with both enables set
// - Burst NMI clears master enable, releases bus
// - Setting master enable again resumes the burst
// - Block mode ignores NMI entirely
// - Master enable cleared by reset, burst NMI, write 0
// - Master enable set only after reading zero
// - Transfer enable gates the selected activation source
// - Transfer enable low ignores activation requests
// - Disabled internal source forwards its interrupt
// - Transfer enable falling raises end interrupt
// - Both enables set, block mode: one transfer per request
// - Transfer enable cleared by reset, count done
// - Writing zero forcibly stops the transfer
// - Transfer enable set only after reading zero or by a controller write
// - Channel 1 master enable falling raises break
// - Break request withdrawn by disable or restart
// - Channel 1 runs only with both enables set
// - Controller writes set transfer enable directly
`ifndef DMAEN_CFG_SVH
`define DMAEN_CFG_SVH

`define DMAEN_OFF_CTRL 8'h00
`define DMAEN_OFF_CFG 8'h04
`define DMAEN_OFF_CNT0 8'h08
`define DMAEN_OFF_CNT1 8'h0C
`define DMAEN_OFF_STAT 8'h10
`define DMAEN_OFF_MASK 8'h14
`define DMAEN_OFF_STATE 8'h18

`define DMAEN_B_C0_END 0
`define DMAEN_B_C1_BRK 3
`define DMAEN_B_C0_TE 4
`define DMAEN_B_C0_ME 5
`define DMAEN_B_C1_TE 6
`define DMAEN_B_C1_ME 7

`define DMAEN_F_SRC0 0
`define DMAEN_B_BURST0 4
`define DMAEN_F_SRC1 8

`define DMAEN_ST_END0 0
`define DMAEN_ST_BRK1 1
`define DMAEN_ST_NMI 2
`define DMAEN_ST_FWD 3

`define DMAEN_INT_SRC_MASK 16'hFF00
`define DMAEN_RST_WAIT 1'b1

`endif

// *** design/dmaen_pkg.sv ***
// Purpose: Types shared by the enable control block
// Assumes: Nothing beyond the header
// Notes: Channel 0 sequencing states
package dmaen_pkg;
   typedef enum logic {
      S_IDLE,
      S_BURST
   } dmaen_st_e;
endpackage

// *** sim/dmaen_src_model.sv ***
// Purpose: Far-side activation sources and strobe counter
// Assumes: Request levels change on ref_clk_i
// Notes: Counts strobes of both channels
module dmaen_src_model (
   // Clock, reset, bench side
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [15:0] req_i,
   output int ch0_n_o,
   output int ch1_n_o,
   // Block side
   input wire logic ch0_xfer_i,
   input wire logic ch1_xfer_i,
   output logic [15:0] act_req_o
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         act_req_o <= 16'h0;
         ch0_n_o <= 0;
         ch1_n_o <= 0;
      end else begin
         act_req_o <= req_i;
         ch0_n_o <= ch0_n_o + int'(ch0_xfer_i);
         ch1_n_o <= ch1_n_o + int'(ch1_xfer_i);
      end
   end
endmodule

// *** sim/dmaen_ctrl_tb.sv ***
// Purpose: Self-checking bench of the enable control block
// Assumes: Byte-addressed map, control word at 0x00
// Notes: One task per scenario
module dmaen_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 1'b0, rst_b_i = 1'b0, rd = 1'b0, wr = 1'b0, data_transfer_controller = 1'b0, nmi = 1'b0;
   logic [7:0] adr = 8'h0;
   logic [31:0] wdat = 32'h0, rdat, rq;
   logic [15:0] req = 16'h0, act;
   logic [1:0] fwd;
   logic wt, x0, x1, bm, eirq, birq, irq;
   int n0, n1, b, err_total = 0, total_checks = 0, cycles = 0;
   dmaen_ctrl uut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .dtc_access_i(data_transfer_controller), .act_req_i(act),
      .nmi_i(nmi), .ch0_xfer_o(x0), .ch1_xfer_o(x1), .bus_master_o(bm), .fwd_irq_o(fwd),
      .ch0_end_irq_o(eirq), .ch1_break_irq_o(birq), .irq_o(irq));
   dmaen_src_model src (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req), .ch0_n_o(n0),
      .ch1_n_o(n1), .ch0_xfer_i(x0), .ch1_xfer_i(x1), .act_req_o(act));
   initial forever #50 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      if (++cycles == 3000) begin
         err_total++;
         give_verdict();
      end
   end
   task give_verdict();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(string nm, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cyc(int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task bus(logic w, logic [7:0] a, logic [31:0] d);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= ~w;
      @(posedge ref_clk_i);
      while (wt !== 1'b0) @(posedge ref_clk_i);
      rq = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task rchk(string nm, logic [7:0] a, logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rq);
   endtask
   task arm_set(logic [31:0] v);
      bus(1'b0, 8'h0, 32'h0);
      bus(1'b1, 8'h0, v);
   endtask
   task t_regs();
      rchk("ctrl rst", 8'h0, 32'h0);
      rchk("unmapped", 8'h40, 32'h0);
      bus(1'b1, 8'h0, 32'h0);
      bus(1'b1, 8'h0, 32'h30);
      rchk("no read", 8'h0, 32'h0);
      arm_set(32'h30);
      rchk("armed", 8'h0, 32'h30);
      bus(1'b1, 8'h0, 32'h0);
      bus(1'b1, 8'h0, 32'h30);
      rchk("cleared", 8'h0, 32'h0);
   endtask
   task t_xfer();
      bus(1'b1, 8'h8, 32'h3);
      bus(1'b1, 8'h14, 32'h1);
      arm_set(32'h31);
      b = n0;
      req <= 16'h1;
      nmi <= 1'b1;
      cyc(2);
      nmi <= 1'b0;
      cyc(8);
      req <= 16'h0;
      chk("ch0 count", 32'h3, n0 - b);
      rchk("te done", 8'h0, 32'h21);
      chk("end irq", 1'b1, eirq);
      chk("irq", 1'b1, irq);
      bus(1'b1, 8'h14, 32'h0);
      chk("masked", 1'b0, irq);
      bus(1'b1, 8'h14, 32'h1);
      bus(1'b1, 8'h10, 32'h1);
      chk("acked", 1'b0, irq);
   endtask
   task t_gate();
      bus(1'b1, 8'h0, 32'h20);
      bus(1'b1, 8'h4, 32'h8);
      bus(1'b1, 8'h8, 32'h2);
      b = n0;
      req <= 16'h100;
      cyc(5);
      chk("gated", 32'h0, n0 - b);
      chk("forward", 2'b01, fwd);
      req <= 16'h1;
      data_transfer_controller <= 1'b1;
      bus(1'b1, 8'h0, 32'h30);
      data_transfer_controller <= 1'b0;
      cyc(5);
      chk("other src", 32'h0, n0 - b);
      req <= 16'h100;
      cyc(5);
      req <= 16'h0;
      chk("selected", 32'h2, n0 - b);
   endtask
   task t_ch1();
      bus(1'b1, 8'h4, 32'h100);
      bus(1'b1, 8'hC, 32'h2);
      arm_set(32'hC8);
      b = n1;
      req <= 16'h2;
      cyc(6);
      req <= 16'h0;
      chk("ch1 count", 32'h2, n1 - b);
      bus(1'b1, 8'h0, 32'h8);
      chk("break", 1'b1, birq);
      arm_set(32'h88);
      chk("break off", 1'b0, birq);
   endtask
   task t_nmi();
      bus(1'b1, 8'h4, 32'h10);
      bus(1'b1, 8'h8, 32'h14);
      arm_set(32'h30);
      b = n0;
      req <= 16'h1;
      cyc(5);
      chk("bus held", 1'b1, bm);
      nmi <= 1'b1;
      cyc(2);
      nmi <= 1'b0;
      cyc(6);
      chk("bus back", 1'b0, bm);
      rchk("me clr", 8'h0, 32'h10);
      rchk("status", 8'h10, 32'hE);
      rchk("state", 8'h18, 32'h4);
      rchk("cnt left", 8'h8, 32'hE);
      arm_set(32'h30);
      cyc(30);
      req <= 16'h0;
      chk("resumed", 32'h14, n0 - b);
   endtask
   initial begin
      cyc(16);
      rst_b_i <= 1'b1;
      cyc(1);
      t_regs();
      t_xfer();
      t_gate();
      t_ch1();
      t_nmi();
      give_verdict();
   end
endmodule
